// File: atc_consts.vh
`ifndef ATC_CONSTS_VH
`define ATC_CONSTS_VH

// Register indices; the bus byte address is four times the index.
`define ATC_IDX_FLAGS       16'h4011
`define ATC_IDX_MASKS       16'h4019
`define ATC_IDX_CMP_CTRL    16'h4030
`define ATC_IDX_CFG_ONE     16'h4031
`define ATC_IDX_CFG_TWO     16'h4032
`define ATC_IDX_CFG_THREE   16'h4033
`define ATC_IDX_CFG_FOUR    16'h4034

// Field positions.
`define ATC_SRC_HI          15
`define ATC_SRC_LO          13
`define ATC_DIR_BIT         12
`define ATC_THR_HI          11
`define ATC_THR_LO          0
`define ATC_READY_BIT       8
`define ATC_EVT_HI          7
`define ATC_EVT_LO          4
`define ATC_RESULT_LO       8
`define ATC_ENABLE_LO       0

// Reset values.
`define ATC_CFG_RESET       16'h0000
`define ATC_FLAGS_RESET     5'h00
`define ATC_MASKS_RESET     5'h1f
`define ATC_ENABLE_RESET    4'h0

// Channel codes.
`define ATC_CH_BACKUP       3'h0
`define ATC_CH_INPUT_A      3'h1
`define ATC_CH_INPUT_B      3'h2
`define ATC_CH_INPUT_C      3'h3
`define ATC_CH_TEMP         3'h5
`define ATC_CH_SUPPLY       3'h7

// Bus answers.
`define ATC_RESP_OKAY       2'h0
`define ATC_RESP_SLVERR     2'h2

`endif

// File: atc_threshold_irq.v
`timescale 1ns/1ps
`default_nettype none
`include "atc_consts.vh"

// Function
// - Units one to three pick channel by 3-bit code: 1,2,3,5,7 valid, others reserved.
// - Unit four alone treats code 0 as the backup battery channel.
// - Direction 0 triggers below threshold, 1 triggers at or above threshold.
// - Threshold is 12-bit unsigned, compared directly with the 12-bit sample.
// - Ready flag and unit flags feed one interrupt; mask bit 1 blocks a flag.
// - Ready flag survives reads; only writing 1 to it clears it.
// - Ready flag is bit 8, set on the rising edge of new data.
// - Unit flags are bits 7 to 4, set per direction, cleared by writing 1.
// - Mask register holds bits 8 and 7 to 4; all reset to 1.
// - All unit configuration fields reset to zero.
// - Compare only right after a conversion on the selected channel.
// - Result bits 8 to 11 of control hold each unit's latest comparison.
// - Enable bits 0 to 3; a disabled unit updates neither result nor flag.
module atc_threshold_irq #(
    parameter ADDR_W = 17,
    parameter UNITS  = 4
) (
    input  wire          clk_sys,
    input  wire          reset_n,
    // Conversion result port: level stays high while a new sample is presented.
    input  wire          sample_ready,
    input  wire [2:0]    sample_channel,
    input  wire [11:0]   sample_data,
    output reg           adc_primary_irq,
    // AXI4-Lite slave.
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire          s_axi_awvalid,
    output reg           s_axi_awready,
    input  wire [31:0]   s_axi_wdata,
    input  wire [3:0]    s_axi_wstrb,
    input  wire          s_axi_wvalid,
    output reg           s_axi_wready,
    output reg  [1:0]    s_axi_bresp,
    output reg           s_axi_bvalid,
    input  wire          s_axi_bready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire          s_axi_arvalid,
    output reg           s_axi_arready,
    output reg  [31:0]   s_axi_rdata,
    output reg  [1:0]    s_axi_rresp,
    output reg           s_axi_rvalid,
    input  wire          s_axi_rready
);

    reg  [15:0]          cfg [0:UNITS-1];
    reg  [UNITS-1:0]     cmp_enable;
    reg  [UNITS-1:0]     cmp_result;
    reg  [4:0]           flags;
    reg  [4:0]           masks;
    reg                  sample_ready_q;
    reg  [ADDR_W-1:0]    wr_addr;
    reg  [15:0]          wr_data;
    reg  [1:0]           wr_strb;

    wire                 new_sample;
    wire                 do_write;
    wire [15:0]          wr_index;
    wire [15:0]          rd_index;
    wire [15:0]          lane_mask;
    wire [15:0]          wr_bits;
    wire [UNITS-1:0]     hit;
    wire [UNITS-1:0]     trig;
    reg  [4:0]           flag_set;
    reg  [4:0]           flag_clr;
    reg  [4:0]           next_flags;
    reg  [4:0]           next_masks;
    reg                  wr_mapped;
    reg  [15:0]          rd_value;
    reg                  rd_mapped;
    integer              i;

    // A held level must not retrigger, so only its rising edge counts.
    assign new_sample = sample_ready & ~sample_ready_q;
    assign do_write   = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
    assign wr_index   = {{(18-ADDR_W){1'b0}}, wr_addr[ADDR_W-1:2]};
    assign rd_index   = {{(18-ADDR_W){1'b0}}, s_axi_araddr[ADDR_W-1:2]};
    assign lane_mask  = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
    assign wr_bits    = wr_data & lane_mask;

    // One comparison unit per threshold; only the last one may watch the backup channel.
    genvar g;
    generate
        for (g = 0; g < UNITS; g = g + 1)
        begin : unit_g
            atc_cmp_unit #(
                .BACKUP_OK      (g == UNITS - 1)
            ) unit_u (
                .cfg_word       (cfg[g]),
                .sample_channel (sample_channel),
                .sample_data    (sample_data),
                .hit            (hit[g]),
                .trig           (trig[g])
            );
        end
    endgenerate

    always @*
    begin
        wr_mapped = 1'b1;
        case (wr_index)
            `ATC_IDX_FLAGS, `ATC_IDX_MASKS, `ATC_IDX_CMP_CTRL,
            `ATC_IDX_CFG_ONE, `ATC_IDX_CFG_TWO, `ATC_IDX_CFG_THREE, `ATC_IDX_CFG_FOUR:
                wr_mapped = 1'b1;
            default:
                wr_mapped = 1'b0;
        endcase
        flag_set = 5'h00;
        flag_clr = 5'h00;
        if (new_sample)
        begin
            flag_set[4] = 1'b1;
            // Unit n sits at event bit n+4, ascending.
            flag_set[3:0] = hit & cmp_enable & trig;
        end
        if (do_write && wr_index == `ATC_IDX_FLAGS)
            flag_clr = {wr_bits[`ATC_READY_BIT], wr_bits[`ATC_EVT_HI:`ATC_EVT_LO]};
        // An event landing with its own clear is kept.
        next_flags = (flags & ~flag_clr) | flag_set;
        next_masks = masks;
        if (do_write && wr_index == `ATC_IDX_MASKS)
        begin
            if (wr_strb[1])
                next_masks[4] = wr_data[`ATC_READY_BIT];
            if (wr_strb[0])
                next_masks[3:0] = wr_data[`ATC_EVT_HI:`ATC_EVT_LO];
        end
    end

    always @*
    begin
        rd_mapped = 1'b1;
        rd_value  = 16'h0000;
        case (rd_index)
            `ATC_IDX_FLAGS:
                rd_value = {7'h00, flags, 4'h0};
            `ATC_IDX_MASKS:
                rd_value = {7'h00, masks, 4'h0};
            `ATC_IDX_CMP_CTRL:
                rd_value = {4'h0, cmp_result, 4'h0, cmp_enable};
            `ATC_IDX_CFG_ONE:
                rd_value = cfg[0];
            `ATC_IDX_CFG_TWO:
                rd_value = cfg[1];
            `ATC_IDX_CFG_THREE:
                rd_value = cfg[2];
            `ATC_IDX_CFG_FOUR:
                rd_value = cfg[3];
            default:
                rd_mapped = 1'b0;
        endcase
    end

    // Control state, flags and comparator results.
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (i = 0; i < UNITS; i = i + 1)
                cfg[i] <= `ATC_CFG_RESET;
            cmp_enable      <= `ATC_ENABLE_RESET;
            cmp_result      <= {UNITS{1'b0}};
            flags           <= `ATC_FLAGS_RESET;
            masks           <= `ATC_MASKS_RESET;
            sample_ready_q  <= 1'b0;
            adc_primary_irq <= 1'b0;
        end
        else
        begin
            sample_ready_q  <= sample_ready;
            flags           <= next_flags;
            masks           <= next_masks;
            adc_primary_irq <= |(next_flags & ~next_masks);
            for (i = 0; i < UNITS; i = i + 1)
            begin
                // Results change only on a fresh conversion of the unit's own channel.
                if (new_sample && hit[i] && cmp_enable[i])
                    cmp_result[i] <= trig[i];
            end
            if (do_write)
            begin
                if (wr_index == `ATC_IDX_CMP_CTRL && wr_strb[0])
                    cmp_enable <= wr_data[`ATC_ENABLE_LO+UNITS-1:`ATC_ENABLE_LO];
                for (i = 0; i < UNITS; i = i + 1)
                begin
                    if (wr_index == `ATC_IDX_CFG_ONE + i[15:0])
                        cfg[i] <= (cfg[i] & ~lane_mask) | wr_bits;
                end
            end
        end
    end

    // Write channel: address and data are taken in either order, then answered.
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `ATC_RESP_OKAY;
            wr_addr       <= {ADDR_W{1'b0}};
            wr_data       <= 16'h0000;
            wr_strb       <= 2'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                wr_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wr_data      <= s_axi_wdata[15:0];
                wr_strb      <= s_axi_wstrb[1:0];
                s_axi_wready <= 1'b0;
            end
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_mapped ? `ATC_RESP_OKAY : `ATC_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Read channel: one read in flight; reads have no side effects.
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `ATC_RESP_OKAY;
        end
        else
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= {16'h0000, rd_value};
                s_axi_rresp   <= rd_mapped ? `ATC_RESP_OKAY : `ATC_RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule // atc_threshold_irq

// Decides whether a presented sample belongs to one unit and whether it trips the threshold.
module atc_cmp_unit #(
    parameter BACKUP_OK = 0
) (
    input  wire [15:0]   cfg_word,
    input  wire [2:0]    sample_channel,
    input  wire [11:0]   sample_data,
    output reg           hit,
    output reg           trig
);

    wire [2:0]           src;
    wire                 dir;
    wire [11:0]          thr;

    assign src = cfg_word[`ATC_SRC_HI:`ATC_SRC_LO];
    assign dir = cfg_word[`ATC_DIR_BIT];
    assign thr = cfg_word[`ATC_THR_HI:`ATC_THR_LO];

    always @*
    begin
        case (src)
            `ATC_CH_INPUT_A, `ATC_CH_INPUT_B, `ATC_CH_INPUT_C,
            `ATC_CH_TEMP, `ATC_CH_SUPPLY:
                hit = (sample_channel == src);
            `ATC_CH_BACKUP:
                hit = (BACKUP_OK != 0) && (sample_channel == `ATC_CH_BACKUP);
            default:
                // Reserved codes never match, so a stray setting stays silent.
                hit = 1'b0;
        endcase
        // Both operands are unsigned 12-bit codes, so no sign handling is needed.
        if (dir)
            trig = (sample_data >= thr);
        else
            trig = (sample_data < thr);
    end

endmodule // atc_cmp_unit

`default_nettype wire

// File: atc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "atc_consts.vh"
module atc_monitor (
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic        sample_ready,
    input wire logic        adc_primary_irq,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered one cycle after address");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
    a_write_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_read_blocks: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    a_err_no_data: assert property (s_axi_rvalid && s_axi_rresp == `ATC_RESP_SLVERR
        |-> s_axi_rdata == 32'h0000_0000) else $error("error read carries data");
    // The interrupt only moves after a new sample or a register write lands.
    a_irq_rise_cause: assert property ($rose(adc_primary_irq) |->
        $past(sample_ready) || $rose(s_axi_bvalid)) else $error("interrupt rose unprompted");
    a_irq_fall_cause: assert property ($fell(adc_primary_irq) |->
        $rose(s_axi_bvalid)) else $error("interrupt fell without a write");
endmodule // atc_monitor
`default_nettype wire

// File: atc_threshold_irq_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "atc_consts.vh"
module atc_threshold_irq_tb;
    logic        clk_sys = 0, reset_n = 0, sample_ready = 0, adc_primary_irq, t;
    logic [2:0]  sample_channel = 0;
    logic [11:0] sample_data = 0, d;
    logic [16:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf, res = 0;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] ef = 0;
    logic [2:0]  src [4] = '{0, 0, 0, 0};
    logic        dir [4] = '{0, 0, 0, 0};
    logic [11:0] thr [4] = '{0, 0, 0, 0};
    int          n_mismatch = 0, checked = 0, k;
    atc_threshold_irq dut_u (.clk_sys, .reset_n, .sample_ready, .sample_channel, .sample_data,
        .adc_primary_irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    initial forever #20 clk_sys = ~clk_sys;
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Each channel is dropped on its own handshake; the watchdog bounds every wait.
    // The answer readies are raised again in every call and never lowered, so they stay high between calls.
    task automatic wr(input logic [15:0] idx, input logic [31:0] v);
        s_axi_awaddr <= {idx[14:0], 2'b00};
        s_axi_wdata <= v;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        forever
        begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) break;
        end
        chk({32'h0, s_axi_bresp}, {32'h0, `ATC_RESP_OKAY});
    endtask
    task automatic rd(input logic [15:0] idx, input logic [33:0] exp);
        s_axi_araddr <= {idx[14:0], 2'b00};
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        forever
        begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) break;
        end
        chk({s_axi_rresp, s_axi_rdata}, exp);
    endtask
    task automatic smp(input logic [2:0] ch, input logic [11:0] v);
        sample_ready <= 1;
        sample_channel <= ch;
        sample_data <= v;
        @(posedge clk_sys);
        sample_ready <= 0;
        sample_data <= ~v;
        @(posedge clk_sys);
    endtask
    initial
    begin
        #100_000;
        n_mismatch++;
        tally_and_finish();
    end
    initial
    begin
        repeat (5) @(posedge clk_sys);
        reset_n <= 1;
        @(posedge clk_sys);
        rd(`ATC_IDX_MASKS, 34'h0_0000_01f0);
        rd(`ATC_IDX_FLAGS, 34'h0);
        for (int j = 0; j < 5; j++) rd(16'(`ATC_IDX_CMP_CTRL + j), 34'h0);
        rd(16'h4012, {`ATC_RESP_SLVERR, 32'h0000_0000});
        smp(`ATC_CH_INPUT_A, 12'h0123);
        rd(`ATC_IDX_FLAGS, 34'h0_0000_0100);
        rd(`ATC_IDX_FLAGS, 34'h0_0000_0100);
        chk({33'h0, adc_primary_irq}, 34'h0);
        wr(`ATC_IDX_MASKS, 32'h0000_00f0);
        chk({33'h0, adc_primary_irq}, 34'h1);
        wr(`ATC_IDX_FLAGS, 32'h0000_0100);
        chk({33'h0, adc_primary_irq}, 34'h0);
        wr(`ATC_IDX_CMP_CTRL, 32'h0000_000f);
        // Every source code and both directions, at and just below the threshold.
        for (int i = 0; i < 12; i++)
        begin
            k = i % 4;
            src[k] = 3'((i / 4 + i) % 8);
            dir[k] = i[0];
            thr[k] = 12'h07fc + 12'(i);
            wr(16'(`ATC_IDX_CFG_ONE + k), {16'h0, src[k], dir[k], thr[k]});
            wr(`ATC_IDX_MASKS, 32'(16'h01f0 ^ (16'h0010 << k)));
            d = i[1] ? thr[k] : thr[k] - 12'h001;
            smp(src[k], d);
            ef[8] = 1;
            for (int j = 0; j < 4; j++)
                if (src[j] == src[k] && (src[j] inside {1, 2, 3, 5, 7}
                    || (j == 3 && src[j] == 0)))
                begin
                    t = dir[j] ? d >= thr[j] : d < thr[j];
                    res[j] = t;
                    ef[4 + j] = ef[4 + j] | t;
                end
            rd(`ATC_IDX_FLAGS, {18'h0, ef});
            rd(`ATC_IDX_CMP_CTRL, {22'h0, res, 8'h0f});
            chk({33'h0, adc_primary_irq}, {33'h0, ef[4 + k]});
            if (i[0])
            begin
                wr(`ATC_IDX_FLAGS, 32'h0000_01f0);
                ef = 0;
            end
        end
        wr(`ATC_IDX_CMP_CTRL, 32'h0000_0000);
        smp(src[3], 12'h0fff);
        rd(`ATC_IDX_FLAGS, 34'h0_0000_0100);
        rd(`ATC_IDX_CMP_CTRL, {22'h0, res, 8'h00});
        tally_and_finish();
    end
endmodule // atc_threshold_irq_tb
bind atc_threshold_irq atc_monitor mon_u (.clk_sys, .reset_n, .sample_ready,
    .adc_primary_irq, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid);
`default_nettype wire
